// ===== logic/irq_source_cell.sv
// One request source: two gated conditions merged into a level and an edge
`timescale 1ns/1ps
module irq_source_cell #(
   parameter bit GATED = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic flagA,
   input wire logic enableA,
   input wire logic flagB,
   input wire logic enableB,
   output logic req,
   output logic rise
);
   logic next_req;
   logic next_rise;

   always_comb
   begin
      if (GATED)
         next_req = (flagA & enableA) | (flagB & enableB);
      else
         next_req = flagA | flagB;
      next_rise = next_req & ~req;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         req <= 1'b0;
         rise <= 1'b0;
      end
      else
      begin
         req <= next_req;
         rise <= next_rise;
      end
   end
endmodule

// ===== logic/serial_irq_dma.sv
// Interrupt and DMA request logic for one channel of the FIFO serial port
//
// Contract
// (R1) Four request outputs: overrun error, underrun error, receive-full, transmit-empty.
// (R2) Receive-full from data or control-data full; transmit-empty from either empty.
// (R3) Receive-full and transmit-empty gated by their enable bits in the control register.
// (R4) Overrun and underrun requests have no enable and always propagate.
// (R5) Priority overrun, underrun, receive-full, transmit-empty; only latter two request DMA.
// (R6) Each request is a level held while flag set and enabled, else drops.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module serial_irq_dma
   import serial_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [serial_irq_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [serial_irq_pkg::DATA_WIDTH-1:0] pwdata,
   output logic [serial_irq_pkg::DATA_WIDTH-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Status flags from the serial data path
   input wire logic rxOverrunFlag,
   input wire logic txUnderrunFlag,
   input wire logic rxDataFullFlag,
   input wire logic rxCtrlDataFullFlag,
   input wire logic txDataEmptyFlag,
   input wire logic txCtrlDataEmptyFlag,
   // Requests to the interrupt controller
   output logic rxOverrunIrq,
   output logic txUnderrunIrq,
   output logic rxFullIrq,
   output logic txEmptyIrq,
   // Requests to the DMA controller
   output logic rxFullDmaReq,
   output logic txEmptyDmaReq,
   // Most urgent live request
   output logic [2:0] topSource,
   // Summary interrupt from sticky events
   output logic irq
);
   import serial_irq_pkg::*;

   logic [CTRL_WIDTH-1:0] serialControlReg;
   logic [CTRL_WIDTH-1:0] next_serialControlReg;
   logic [SRC_COUNT-1:0] eventStatus;
   logic [SRC_COUNT-1:0] next_eventStatus;
   logic [SRC_COUNT-1:0] eventMask;
   logic [SRC_COUNT-1:0] next_eventMask;
   logic [DATA_WIDTH-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;
   logic next_rxFullDmaReq;
   logic next_txEmptyDmaReq;
   top_source_t topPending;
   top_source_t next_topPending;

   logic [SRC_COUNT-1:0] srcReq;
   logic [SRC_COUNT-1:0] srcRise;
   logic [SRC_COUNT-1:0] srcFlagA;
   logic [SRC_COUNT-1:0] srcFlagB;
   logic [SRC_COUNT-1:0] srcEnA;
   logic [SRC_COUNT-1:0] srcEnB;

   logic accessDone;
   logic writeDone;
   logic readDone;
   logic addrHit;

   // Source wiring; error sources take no enable
   always_comb
   begin
      srcFlagA = 4'h0;
      srcFlagB = 4'h0;
      srcEnA = 4'h0;
      srcEnB = 4'h0;
      srcFlagA[SRC_OVERRUN] = rxOverrunFlag; // R4
      srcFlagA[SRC_UNDERRUN] = txUnderrunFlag; // R4
      srcFlagA[SRC_RX_FULL] = rxDataFullFlag; // R2
      srcFlagB[SRC_RX_FULL] = rxCtrlDataFullFlag; // R2
      srcFlagA[SRC_TX_EMPTY] = txDataEmptyFlag; // R2
      srcFlagB[SRC_TX_EMPTY] = txCtrlDataEmptyFlag; // R2
      srcEnA[SRC_RX_FULL] = serialControlReg[CTRL_RX_DATA_EN_BIT]; // R3
      srcEnB[SRC_RX_FULL] = serialControlReg[CTRL_RX_CTRL_EN_BIT]; // R3
      srcEnA[SRC_TX_EMPTY] = serialControlReg[CTRL_TX_DATA_EN_BIT]; // R3
      srcEnB[SRC_TX_EMPTY] = serialControlReg[CTRL_TX_CTRL_EN_BIT]; // R3
   end

   // One cell per source: registered level plus rising edge
   irq_source_cell #(.GATED(1'b0)) overrunCell (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flagA(srcFlagA[SRC_OVERRUN]),
      .enableA(srcEnA[SRC_OVERRUN]),
      .flagB(srcFlagB[SRC_OVERRUN]),
      .enableB(srcEnB[SRC_OVERRUN]),
      .req(srcReq[SRC_OVERRUN]),
      .rise(srcRise[SRC_OVERRUN])
   );

   irq_source_cell #(.GATED(1'b0)) underrunCell (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flagA(srcFlagA[SRC_UNDERRUN]),
      .enableA(srcEnA[SRC_UNDERRUN]),
      .flagB(srcFlagB[SRC_UNDERRUN]),
      .enableB(srcEnB[SRC_UNDERRUN]),
      .req(srcReq[SRC_UNDERRUN]),
      .rise(srcRise[SRC_UNDERRUN])
   );

   irq_source_cell #(.GATED(1'b1)) rxFullCell (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flagA(srcFlagA[SRC_RX_FULL]),
      .enableA(srcEnA[SRC_RX_FULL]),
      .flagB(srcFlagB[SRC_RX_FULL]),
      .enableB(srcEnB[SRC_RX_FULL]),
      .req(srcReq[SRC_RX_FULL]),
      .rise(srcRise[SRC_RX_FULL])
   );

   irq_source_cell #(.GATED(1'b1)) txEmptyCell (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .flagA(srcFlagA[SRC_TX_EMPTY]),
      .enableA(srcEnA[SRC_TX_EMPTY]),
      .flagB(srcFlagB[SRC_TX_EMPTY]),
      .enableB(srcEnB[SRC_TX_EMPTY]),
      .req(srcReq[SRC_TX_EMPTY]),
      .rise(srcRise[SRC_TX_EMPTY])
   );

   // The four request lines are the cell flip-flops themselves
   assign rxOverrunIrq = srcReq[SRC_OVERRUN]; // R1 R6
   assign txUnderrunIrq = srcReq[SRC_UNDERRUN]; // R1 R6
   assign rxFullIrq = srcReq[SRC_RX_FULL]; // R1 R6
   assign txEmptyIrq = srcReq[SRC_TX_EMPTY]; // R1 R6
   assign topSource = topPending;

   // APB decode; pready adds one wait state so all answers are registered
   assign accessDone = psel & penable & pready;
   assign writeDone = accessDone & pwrite;
   assign readDone = accessDone & ~pwrite;

   always_comb
   begin
      case (paddr)
         CTRL_OFFSET,
         SOURCE_OFFSET,
         EVENT_OFFSET,
         MASK_OFFSET,
         TOP_OFFSET:
            addrHit = 1'b1;
         default:
            addrHit = 1'b0;
      endcase
   end

   always_comb
   begin
      next_pready = psel & penable & ~pready;
      next_pslverr = psel & penable & ~pready & ~addrHit;
      next_prdata = prdata;
      if (psel && penable && !pready)
      begin
         next_prdata = '0;
         if (!pwrite)
         begin
            case (paddr)
               CTRL_OFFSET:
                  next_prdata[CTRL_WIDTH-1:0] = serialControlReg;
               SOURCE_OFFSET:
               begin
                  next_prdata[5:0] = {txCtrlDataEmptyFlag, txDataEmptyFlag, rxCtrlDataFullFlag,
                                      rxDataFullFlag, txUnderrunFlag, rxOverrunFlag};
                  next_prdata[SOURCE_REQ_LSB +: SRC_COUNT] = srcReq;
               end
               EVENT_OFFSET:
                  next_prdata[SRC_COUNT-1:0] = eventStatus;
               MASK_OFFSET:
                  next_prdata[SRC_COUNT-1:0] = eventMask;
               TOP_OFFSET:
                  next_prdata[2:0] = topPending;
               default:
                  next_prdata = '0;
            endcase
         end
      end
   end

   // Register state; reading events clears them but a new edge wins
   always_comb
   begin
      next_serialControlReg = serialControlReg;
      next_eventMask = eventMask;
      next_eventStatus = eventStatus;
      if (writeDone && paddr == CTRL_OFFSET)
         next_serialControlReg = pwdata[CTRL_WIDTH-1:0];
      if (writeDone && paddr == MASK_OFFSET)
         next_eventMask = pwdata[SRC_COUNT-1:0];
      if (readDone && paddr == EVENT_OFFSET)
         next_eventStatus = EVENT_RESET;
      next_eventStatus = next_eventStatus | srcRise;
   end

   // Fixed ranking and DMA routing from live requests
   always_comb
   begin
      if (srcReq[SRC_OVERRUN])
         next_topPending = TOP_OVERRUN; // R5
      else if (srcReq[SRC_UNDERRUN])
         next_topPending = TOP_UNDERRUN; // R5
      else if (srcReq[SRC_RX_FULL])
         next_topPending = TOP_RX_FULL; // R5
      else if (srcReq[SRC_TX_EMPTY])
         next_topPending = TOP_TX_EMPTY; // R5
      else
         next_topPending = TOP_NONE;
      // Error sources never reach the DMA controller
      next_rxFullDmaReq = srcReq[SRC_RX_FULL] & serialControlReg[CTRL_RX_DMA_EN_BIT]; // R5
      next_txEmptyDmaReq = srcReq[SRC_TX_EMPTY] & serialControlReg[CTRL_TX_DMA_EN_BIT]; // R5
      next_irq = |(next_eventStatus & next_eventMask);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         serialControlReg <= CTRL_RESET;
         eventStatus <= EVENT_RESET;
         eventMask <= MASK_RESET;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
         rxFullDmaReq <= 1'b0;
         txEmptyDmaReq <= 1'b0;
         topPending <= TOP_NONE;
      end
      else
      begin
         serialControlReg <= next_serialControlReg;
         eventStatus <= next_eventStatus;
         eventMask <= next_eventMask;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
         rxFullDmaReq <= next_rxFullDmaReq;
         txEmptyDmaReq <= next_txEmptyDmaReq;
         topPending <= next_topPending;
      end
   end
endmodule

// ===== logic/serial_irq_pkg.sv
// Shared constants for the serial port interrupt and DMA request block
package serial_irq_pkg;
   // APB byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] SOURCE_OFFSET = 8'h04;
   localparam logic [7:0] EVENT_OFFSET = 8'h08;
   localparam logic [7:0] MASK_OFFSET = 8'h0c;
   localparam logic [7:0] TOP_OFFSET = 8'h10;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;

   // Control register fields
   localparam int CTRL_RX_DATA_EN_BIT = 0;
   localparam int CTRL_RX_CTRL_EN_BIT = 1;
   localparam int CTRL_TX_DATA_EN_BIT = 2;
   localparam int CTRL_TX_CTRL_EN_BIT = 3;
   localparam int CTRL_RX_DMA_EN_BIT = 4;
   localparam int CTRL_TX_DMA_EN_BIT = 5;
   localparam int CTRL_WIDTH = 6;
   localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;

   // Source index, also the bit order of event, mask and request fields
   localparam int SRC_OVERRUN = 0;
   localparam int SRC_UNDERRUN = 1;
   localparam int SRC_RX_FULL = 2;
   localparam int SRC_TX_EMPTY = 3;
   localparam int SRC_COUNT = 4;
   localparam logic [SRC_COUNT-1:0] EVENT_RESET = 4'h0;
   localparam logic [SRC_COUNT-1:0] MASK_RESET = 4'h0;

   // Source register: raw flags in bits 5:0, live requests in bits 11:8
   localparam int SOURCE_REQ_LSB = 8;

   // Highest pending request, most urgent first
   typedef enum logic [2:0] {
      TOP_NONE,
      TOP_OVERRUN,
      TOP_UNDERRUN,
      TOP_RX_FULL,
      TOP_TX_EMPTY
   } top_source_t;
endpackage

// ===== tb/dma_ctrl_model.sv
// Behavioural DMA controller that drains the receive data register
`timescale 1ns/1ps
module dma_ctrl_model #(
   parameter int LAG = 3
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic fill,
   input wire logic dmaReq,
   output logic fullFlag
);
   int cnt;
   // Empties only after LAG+1 cycles of request, like a busy bus
   always @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         fullFlag <= 1'b0;
         cnt <= 0;
      end
      else if (fill)
         fullFlag <= 1'b1;
      else if (dmaReq && fullFlag)
      begin
         cnt <= (cnt == LAG) ? 0 : cnt + 1;
         if (cnt == LAG)
            fullFlag <= 1'b0;
      end
   end
endmodule

// ===== tb/serial_irq_dma_monitor.sv
// Concurrent checks on the request outputs and the register handshake
`timescale 1ns/1ps
module serial_irq_dma_monitor
   import serial_irq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic rxOverrunFlag,
   input wire logic txUnderrunFlag,
   input wire logic rxDataFullFlag,
   input wire logic rxCtrlDataFullFlag,
   input wire logic txDataEmptyFlag,
   input wire logic txCtrlDataEmptyFlag,
   input wire logic rxOverrunIrq,
   input wire logic txUnderrunIrq,
   input wire logic rxFullIrq,
   input wire logic txEmptyIrq,
   input wire logic rxFullDmaReq,
   input wire logic txEmptyDmaReq,
   input wire logic [2:0] topSource
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence
   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_pulse;
      pready |=> !pready;
   endproperty
   property p_ovr;
      rxOverrunFlag |=> rxOverrunIrq;
   endproperty
   property p_udr;
      txUnderrunFlag |=> txUnderrunIrq;
   endproperty
   property p_rx_cause;
      rxFullIrq |-> $past(rxDataFullFlag || rxCtrlDataFullFlag);
   endproperty
   property p_tx_cause;
      txEmptyIrq |-> $past(txDataEmptyFlag || txCtrlDataEmptyFlag);
   endproperty
   property p_idle;
      !(rxOverrunFlag || txUnderrunFlag || rxDataFullFlag || rxCtrlDataFullFlag || txDataEmptyFlag
         || txCtrlDataEmptyFlag) |=> !(rxOverrunIrq || txUnderrunIrq || rxFullIrq || txEmptyIrq);
   endproperty
   property p_dma;
      (rxFullDmaReq |-> $past(rxFullIrq)) and (txEmptyDmaReq |-> $past(txEmptyIrq));
   endproperty
   property p_rank;
      rxOverrunIrq |=> topSource == TOP_OVERRUN;
   endproperty
   property p_rank2;
      txUnderrunIrq && !rxOverrunIrq |=> topSource == TOP_UNDERRUN;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer after one wait state");
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   a_ovr: assert property (p_ovr) else $error("overrun request missing");
   a_udr: assert property (p_udr) else $error("underrun request missing");
   a_rx_cause: assert property (p_rx_cause) else $error("receive-full without cause");
   a_tx_cause: assert property (p_tx_cause) else $error("transmit-empty without cause");
   a_idle: assert property (p_idle) else $error("request held with no flag");
   a_dma: assert property (p_dma) else $error("transfer request without source");
   a_rank: assert property (p_rank) else $error("overrun not ranked first");
   a_rank2: assert property (p_rank2) else $error("underrun not ranked second");
endmodule

bind serial_irq_dma serial_irq_dma_monitor serial_irq_dma_monitor_i (.sys_clk(sys_clk), .rstn(rstn),
   .psel(psel), .penable(penable), .pready(pready), .rxOverrunFlag(rxOverrunFlag), .txUnderrunFlag(txUnderrunFlag),
   .rxDataFullFlag(rxDataFullFlag), .rxCtrlDataFullFlag(rxCtrlDataFullFlag), .txDataEmptyFlag(txDataEmptyFlag),
   .txCtrlDataEmptyFlag(txCtrlDataEmptyFlag), .rxOverrunIrq(rxOverrunIrq), .txUnderrunIrq(txUnderrunIrq),
   .rxFullIrq(rxFullIrq), .txEmptyIrq(txEmptyIrq), .rxFullDmaReq(rxFullDmaReq), .txEmptyDmaReq(txEmptyDmaReq),
   .topSource(topSource));

// ===== tb/serial_irq_dma_test.sv
// Register-level test of the serial interrupt and DMA request block
`timescale 1ns/1ps
module serial_irq_dma_test;
   import serial_irq_pkg::*;
   logic sys_clk, rstn, psel, penable, pwrite, ovr, udr, fill, fullRx, err, pready, pslverr;
   logic rxOverrunIrq, txUnderrunIrq, rxFullIrq, txEmptyIrq, rxFullDmaReq, txEmptyDmaReq, irq, seen;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] topSource;
   logic [3:1] fl;
   int bad_count = 0;
   int n_compared = 0;
   int i;

   serial_irq_dma serial_irq_dma_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxOverrunFlag(ovr), .txUnderrunFlag(udr), .rxDataFullFlag(fullRx), .rxCtrlDataFullFlag(fl[1]),
      .txDataEmptyFlag(fl[2]), .txCtrlDataEmptyFlag(fl[3]), .rxOverrunIrq(rxOverrunIrq),
      .txUnderrunIrq(txUnderrunIrq), .rxFullIrq(rxFullIrq), .txEmptyIrq(txEmptyIrq),
      .rxFullDmaReq(rxFullDmaReq), .txEmptyDmaReq(txEmptyDmaReq), .topSource(topSource), .irq(irq));
   dma_ctrl_model #(.LAG(3)) dma_ctrl_model_i (.sys_clk(sys_clk), .rstn(rstn), .fill(fill),
      .dmaReq(rxFullDmaReq), .fullFlag(fullRx));

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask

   // Settle point one nanosecond past the edge keeps reads race free
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial
   begin
      {rstn, psel, penable, pwrite, ovr, udr, fill} = 7'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fl = 3'h0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, MASK_OFFSET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
      $display("test reset values done");
      apb(1'b1, CTRL_OFFSET, 32'h30);
      ovr <= 1'b1;
      udr <= 1'b1;
      wt(3);
      chk(rxOverrunIrq, 1'b1);
      chk(topSource, TOP_OVERRUN);
      chk(rxFullDmaReq, 1'b0);
      ovr <= 1'b0;
      wt(3);
      chk({rxOverrunIrq, txUnderrunIrq}, 2'h1);
      apb(1'b0, TOP_OFFSET, 32'h0);
      chk(rd[2:0], TOP_UNDERRUN);
      udr <= 1'b0;
      $display("test error sources done");
      for (i = 1; i < 4; i++)
      begin
         apb(1'b1, CTRL_OFFSET, (32'h1 << i) | 32'h20);
         fl[i] <= 1'b1;
         wt(3);
         chk({rxFullIrq, txEmptyIrq, txEmptyDmaReq}, {i == 1, i > 1, i > 1});
         apb(1'b1, CTRL_OFFSET, 32'h0);
         wt(2);
         chk({rxFullIrq, txEmptyIrq, txEmptyDmaReq}, 3'h0);
         fl[i] <= 1'b0;
      end
      apb(1'b1, CTRL_OFFSET, 32'h6);
      fl <= 3'h3;
      wt(3);
      chk(topSource, TOP_RX_FULL);
      fl <= 3'h0;
      $display("test gated sources done");
      apb(1'b0, EVENT_OFFSET, 32'h0);
      apb(1'b1, MASK_OFFSET, 32'h4);
      apb(1'b1, CTRL_OFFSET, 32'h11);
      fill <= 1'b1;
      wt(1);
      fill <= 1'b0;
      seen = 1'b0;
      for (i = 0; i < 10 && !seen; i++)
      begin
         wt(1);
         seen = (rxFullDmaReq === 1'b1);
      end
      if (!seen)
      begin
         bad_count++;
         report_and_stop();
      end
      wt(10);
      chk({fullRx, rxFullIrq, irq}, 3'h1);
      apb(1'b0, EVENT_OFFSET, 32'h0);
      chk(rd[3:0], 4'h4);
      wt(3);
      chk(irq, 1'b0);
      ovr <= 1'b1;
      wt(4);
      chk(irq, 1'b0);
      ovr <= 1'b0;
      apb(1'b1, MASK_OFFSET, 32'h1);
      wt(2);
      chk(irq, 1'b1);
      apb(1'b0, EVENT_OFFSET, 32'h0);
      chk(rd[3:0], 4'h1);
      wt(3);
      chk(irq, 1'b0);
      $display("test transfer and interrupt done");
      report_and_stop();
   end
endmodule
